// File: include/pmc_evt_if.sv
// synchronised pin levels passed from the synchroniser to the controller
`timescale 1ns/1ps
interface pmc_evt_if;
   import pmc_pkg::*;
   logic [SYNC_W-1:0] lvl;
   modport src (output lvl);
   modport dst (input lvl);
endinterface

// File: include/pmc_pkg.sv
// constants, register map and types of the power mode controller
package pmc_pkg;
   // register bus
   localparam int         AW        = 8;
   localparam int         DW        = 32;
   localparam logic [7:0] OFS_CTRL  = 8'h00;
   localparam logic [7:0] OFS_ENTER = 8'h04;
   localparam logic [7:0] OFS_STAT  = 8'h08;
   localparam logic [7:0] OFS_MASK  = 8'h0C;
   localparam logic [7:0] OFS_STATE = 8'h10;
   localparam logic [7:0] OFS_BKP   = 8'h14;
   // control register fields
   localparam int         CTL_LP    = 0;
   localparam int         CTL_DETEN = 1;
   localparam int         CTL_RISE  = 2;
   localparam int         CTL_FALL  = 3;
   localparam int         CTL_LVL   = 4;
   localparam int         CTRL_W    = 7;
   localparam logic [6:0] CTRL_RST  = 7'h00;
   // low-power entry codes
   localparam logic [1:0] ENT_SLEEP = 2'h1;
   localparam logic [1:0] ENT_STOP  = 2'h2;
   localparam logic [1:0] ENT_STBY  = 2'h3;
   // status and mask fields
   localparam int         ST_DET    = 0;
   localparam int         ST_STOPWK = 1;
   localparam int         ST_STBYWK = 2;
   localparam int         ST_W      = 3;
   localparam logic [2:0] ST_RST    = 3'h0;
   // regulator mode codes
   localparam logic [1:0] REG_MAIN  = 2'h0;
   localparam logic [1:0] REG_LP    = 2'h1;
   localparam logic [1:0] REG_OFF   = 2'h2;
   // synchronised pin vector layout
   localparam int          SX_SUP   = 0;
   localparam int          SX_DET   = 1;
   localparam int          SX_RSTN  = 2;
   localparam int          SX_WAKE  = 3;
   localparam int          SX_ALARM = 4;
   localparam int          SX_WDOG  = 5;
   localparam int          SX_LINE  = 6;
   localparam int          SYNC_W   = 22;
   localparam logic [21:0] SYNC_RST = 22'h000004;
   // reset hold time
   localparam int         CLK_PS       = 4000;
   localparam int         T_RST_HOLD_PS = 100000;
   localparam int         RST_HOLD_CYC = (T_RST_HOLD_PS + CLK_PS - 1) / CLK_PS;
   localparam logic [4:0] RST_HOLD_LAST = 5'(RST_HOLD_CYC - 1);
   typedef enum logic [2:0] {PM_RESET, PM_RUN, PM_SLEEP, PM_STOP, PM_STBY} pmc_state_t;
endpackage

// File: src/pmc_pvd.sv
// supply voltage detector edge logic
`timescale 1ns/1ps
module pmc_det
(
   // clock and reset
   input  wire logic mclk,
   input  wire logic rst_n,
   // configuration
   input  wire logic en,
   input  wire logic rise_en,
   input  wire logic fall_en,
   // comparator level, high while supply is under the threshold
   input  wire logic below,
   // results
   output logic      out,
   output logic      evt
);
   logic prev_reg;
   logic act_reg;
   logic out_reg;
   logic evt_reg;
   logic evt_next;

   // first enabled cycle only records the level, so enabling raises no event
   assign evt_next = en & act_reg & ((fall_en & below & ~prev_reg) |
                                     (rise_en & ~below & prev_reg));
   assign out = out_reg;
   assign evt = evt_reg;

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prev_reg <= 1'b0;
         act_reg  <= 1'b0;
         out_reg  <= 1'b0;
         evt_reg  <= 1'b0;
      end
      else
      begin
         prev_reg <= below;
         act_reg  <= en;
         out_reg  <= en & below;
         evt_reg  <= evt_next;
      end
   end
endmodule // pmc_det

// File: src/pmc_sync3.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pmc_sync3
   import pmc_pkg::*;
(
   // clock and reset
   input  wire logic              mclk,
   input  wire logic              rst_n,
   // raw pins
   input  wire logic [SYNC_W-1:0] pin,
   // filtered levels
   pmc_evt_if.src                 evt
);
   logic [SYNC_W-1:0] ff1_reg;
   logic [SYNC_W-1:0] ff2_reg;
   logic [SYNC_W-1:0] ff3_reg;
   logic [SYNC_W-1:0] q_reg;
   logic [SYNC_W-1:0] q_next;

   // a change counts only once stages two and three agree
   assign q_next  = ((ff2_reg ~^ ff3_reg) & ff2_reg) | ((ff2_reg ^ ff3_reg) & q_reg);
   assign evt.lvl = q_reg;

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ff1_reg <= SYNC_RST;
         ff2_reg <= SYNC_RST;
         ff3_reg <= SYNC_RST;
         q_reg   <= SYNC_RST;
      end
      else
      begin
         ff1_reg <= pin;
         ff2_reg <= ff1_reg;
         ff3_reg <= ff2_reg;
         q_reg   <= q_next;
      end
   end
endmodule // pmc_sync3

// File: src/pmc_top.sv
// power mode controller: reset hold, detector, regulator and low-power sequencing
`timescale 1ns/1ps
// Overview of operation
// - hold core in reset while supply low
// - detector interrupts on falling, rising or both
// - detector inactive until software enables it
// - regulator main in run, low-power in stop
// - regulator off leaves core unpowered, contents lost
// - regulator on after reset, off only standby
// - sleep halts cpu clock, any event except the wake pin wakes
// - stop gates core clocks and fast oscillators
// - stop regulator mode chosen before entry
// - stop exits on line, detector or alarm
// - standby switches off regulator and fast oscillators
// - standby exits on reset pin, watchdog, wake, alarm
// - slow clocks keep running in stop, standby
// - backup register survives core resets and standby
module pmc_top
   import pmc_pkg::*;
(
   // clock and reset
   input  wire logic          mclk,
   input  wire logic          rst_n,
   // register port
   input  wire logic [AW-1:0] reg_addr,
   input  wire logic [DW-1:0] reg_wdata,
   input  wire logic          reg_wr,
   input  wire logic          reg_rd,
   output logic      [DW-1:0] reg_rdata,
   output logic               irq,
   // supply monitors
   input  wire logic          power_down_reset_detect,
   input  wire logic          supply_voltage_detector,
   output logic               detector_en,
   output logic      [2:0]    detector_threshold,
   // reset and wake-up sources
   input  wire logic          external_reset_pin_n,
   input  wire logic          wake_up_pin,
   input  wire logic          alarm,
   input  wire logic          independent_watchdog,
   input  wire logic [15:0]   external_interrupt_lines,
   input  wire logic          periph_event,
   // core control
   output logic               core_rst_n,
   output logic               cpu_clk_en,
   output logic               core_clk_en,
   output logic      [2:0]    fast_clocks_en,
   output logic               slow_clocks_en,
   // regulator
   output logic               regulator_en,
   output logic      [1:0]    regulator_mode
);
   function automatic logic rise(input logic cur, input logic prev);
      return cur & ~prev;
   endfunction

   pmc_evt_if ev ();

   logic [SYNC_W-1:0] pin_vec;
   logic [SYNC_W-1:0] prev_reg;
   pmc_state_t        state_reg;
   pmc_state_t        state_next;
   logic [4:0]        cnt_reg;
   logic [CTRL_W-1:0] ctrl_reg;
   logic [ST_W-1:0]   stat_reg;
   logic [ST_W-1:0]   stat_next;
   logic [ST_W-1:0]   stat_set;
   logic [ST_W-1:0]   mask_reg;
   logic [DW-1:0]     bkp_reg;
   logic [DW-1:0]     rdata_reg;
   logic [DW-1:0]     rd_mux;
   logic              irq_reg;
   logic              det_en_reg;
   logic [2:0]        det_lvl_reg;
   logic              core_rst_n_reg;
   logic              cpu_clk_reg;
   logic              core_clk_reg;
   logic [2:0]        fast_reg;
   logic              slow_reg;
   logic              reg_en_reg;
   logic [1:0]        reg_mode_reg;
   logic [1:0]        mode_next;
   logic              sup_ok;
   logic              hard_rst;
   logic              core_rst;
   logic              wake_rise;
   logic              alarm_rise;
   logic              line_rise;
   logic              det_out;
   logic              det_evt;
   logic              wr_en;
   logic              enter_wr;
   logic [1:0]        enter_code;
   logic              sleep_wake;
   logic              stop_wake;
   logic              stby_wake;

   assign pin_vec = {external_interrupt_lines, independent_watchdog, alarm, wake_up_pin,
                     external_reset_pin_n, supply_voltage_detector, power_down_reset_detect};

   pmc_sync3 u_sync (
      .mclk (mclk),
      .rst_n(rst_n),
      .pin  (pin_vec),
      .evt  (ev)
   );

   pmc_det u_det (
      .mclk   (mclk),
      .rst_n  (rst_n),
      .en     (ctrl_reg[CTL_DETEN]),
      .rise_en(ctrl_reg[CTL_RISE]),
      .fall_en(ctrl_reg[CTL_FALL]),
      .below  (ev.lvl[SX_DET]),
      .out    (det_out),
      .evt    (det_evt)
   );

   // event decode
   assign sup_ok     = ev.lvl[SX_SUP];
   assign hard_rst   = ~sup_ok | ~ev.lvl[SX_RSTN] | ev.lvl[SX_WDOG];
   assign core_rst   = (state_reg == PM_RESET) || (state_reg == PM_STBY);
   assign wake_rise  = rise(ev.lvl[SX_WAKE], prev_reg[SX_WAKE]);
   assign alarm_rise = rise(ev.lvl[SX_ALARM], prev_reg[SX_ALARM]);
   assign line_rise  = |(ev.lvl[SX_LINE +: 16] & ~prev_reg[SX_LINE +: 16]);
   assign sleep_wake = periph_event | irq_reg | line_rise | det_evt | alarm_rise;
   assign stop_wake  = line_rise | det_evt | alarm_rise;
   assign stby_wake  = wake_rise | alarm_rise;

   // register port decode; the core cannot reach registers while held in reset
   assign wr_en      = reg_wr & ~core_rst;
   assign enter_wr   = wr_en && (reg_addr == OFS_ENTER) && (state_reg == PM_RUN);
   assign enter_code = reg_wdata[1:0];

   // sequencer
   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         PM_RESET:
            if (!hard_rst && cnt_reg == RST_HOLD_LAST)
               state_next = PM_RUN;
         PM_RUN:
            if (enter_wr && enter_code == ENT_SLEEP)
               state_next = PM_SLEEP;
            else if (enter_wr && enter_code == ENT_STOP)
               state_next = PM_STOP;
            else if (enter_wr && enter_code == ENT_STBY)
               state_next = PM_STBY;
         PM_SLEEP:
            if (sleep_wake)
               state_next = PM_RUN;
         PM_STOP:
            if (stop_wake)
               state_next = PM_RUN;
         PM_STBY:
            if (stby_wake)
               state_next = PM_RESET;
      endcase
      if (hard_rst)
         state_next = PM_RESET;
   end

   // stop picks its regulator mode from the setting made before entry
   assign mode_next = (state_next == PM_STBY) ? REG_OFF :
                      (state_next == PM_STOP && ctrl_reg[CTL_LP]) ? REG_LP :
                      REG_MAIN;

   // status: a hardware set wins over a write-one clear in the same cycle
   assign stat_set  = {(state_reg == PM_STBY) && (state_next == PM_RESET) && !hard_rst,
                       (state_reg == PM_STOP) && (state_next == PM_RUN),
                       det_evt};
   assign stat_next = (stat_reg & ~((wr_en && reg_addr == OFS_STAT) ?
                       reg_wdata[ST_W-1:0] : ST_RST)) | stat_set;

   assign rd_mux = (reg_addr == OFS_CTRL)  ? {{(DW-CTRL_W){1'b0}}, ctrl_reg} :
                   (reg_addr == OFS_STAT)  ? {{(DW-ST_W){1'b0}}, stat_reg} :
                   (reg_addr == OFS_MASK)  ? {{(DW-ST_W){1'b0}}, mask_reg} :
                   (reg_addr == OFS_STATE) ? {28'h0000000, det_out, 3'(state_reg)} :
                   (reg_addr == OFS_BKP)   ? bkp_reg : 32'h00000000;

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg <= PM_RESET;
         cnt_reg   <= 5'h00;
         prev_reg  <= SYNC_RST;
      end
      else
      begin
         state_reg <= state_next;
         prev_reg  <= ev.lvl;
         cnt_reg   <= (state_reg == PM_RESET && !hard_rst) ? cnt_reg + 5'h01 : 5'h00;
      end
   end

   // core-domain registers lose their contents whenever the core is held in reset
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_reg <= CTRL_RST;
         mask_reg <= ST_RST;
      end
      else if (core_rst)
      begin
         ctrl_reg <= CTRL_RST;
         mask_reg <= ST_RST;
      end
      else if (wr_en && reg_addr == OFS_CTRL)
         ctrl_reg <= reg_wdata[CTRL_W-1:0];
      else if (wr_en && reg_addr == OFS_MASK)
         mask_reg <= reg_wdata[ST_W-1:0];
   end

   // the standby wake flag sits in the standby circuitry and survives the wake reset
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         stat_reg <= ST_RST;
      else if (core_rst)
         stat_reg <= {stat_next[ST_STBYWK], 2'b00};
      else
         stat_reg <= stat_next;
   end

   // backup register: only the always-on reset clears it
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         bkp_reg <= 32'h00000000;
      else if (wr_en && reg_addr == OFS_BKP)
         bkp_reg <= reg_wdata;
   end

   // outputs, registered; the mode outputs come from the next state so they track the state register
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rdata_reg      <= 32'h00000000;
         irq_reg        <= 1'b0;
         det_en_reg     <= 1'b0;
         det_lvl_reg    <= 3'h0;
         core_rst_n_reg <= 1'b0;
         cpu_clk_reg    <= 1'b0;
         core_clk_reg   <= 1'b1;
         fast_reg       <= 3'h7;
         slow_reg       <= 1'b1;
         reg_en_reg     <= 1'b1;
         reg_mode_reg   <= REG_MAIN;
      end
      else
      begin
         rdata_reg      <= (reg_rd && !core_rst) ? rd_mux : 32'h00000000;
         irq_reg        <= |(stat_next & mask_reg);
         det_en_reg     <= ctrl_reg[CTL_DETEN];
         det_lvl_reg    <= ctrl_reg[CTL_LVL +: 3];
         core_rst_n_reg <= (state_next != PM_RESET) && (state_next != PM_STBY);
         cpu_clk_reg    <= state_next == PM_RUN;
         core_clk_reg   <= (state_next != PM_STOP) && (state_next != PM_STBY);
         fast_reg       <= {3{(state_next != PM_STOP) && (state_next != PM_STBY)}};
         slow_reg       <= 1'b1;
         reg_en_reg     <= state_next != PM_STBY;
         reg_mode_reg   <= mode_next;
      end
   end

   assign reg_rdata          = rdata_reg;
   assign irq                = irq_reg;
   assign detector_en        = det_en_reg;
   assign detector_threshold = det_lvl_reg;
   assign core_rst_n         = core_rst_n_reg;
   assign cpu_clk_en         = cpu_clk_reg;
   assign core_clk_en        = core_clk_reg;
   assign fast_clocks_en     = fast_reg;
   assign slow_clocks_en     = slow_reg;
   assign regulator_en       = reg_en_reg;
   assign regulator_mode     = reg_mode_reg;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sequence s_sleep_evt;
      state_reg == PM_SLEEP && periph_event && !hard_rst;
   endsequence
   sequence s_stby_wake;
      state_reg == PM_STBY && wake_rise && !hard_rst;
   endsequence
   sequence s_boot_hold;
      (regulator_en && !core_rst_n) [*8];
   endsequence

   property p_sup_low;
      !sup_ok |=> state_reg == PM_RESET ##1 !core_rst_n;
   endproperty
   a_sup_low : assert property (p_sup_low) else $error("supply low without reset");

   property p_det_irq;
      det_evt && mask_reg[ST_DET] && state_reg == PM_RUN && !hard_rst && !reg_wr |=> irq;
   endproperty
   a_det_irq : assert property (p_det_irq) else $error("detector event lost");

   property p_det_off;
      !ctrl_reg[CTL_DETEN] && !$past(ctrl_reg[CTL_DETEN]) |-> !det_evt && !det_out;
   endproperty
   a_det_off : assert property (p_det_off) else $error("detector active while off");

   property p_reg_on;
      state_reg != PM_STBY |-> regulator_en && regulator_mode != REG_OFF;
   endproperty
   a_reg_on : assert property (p_reg_on) else $error("regulator off outside standby");

   property p_sleep_wake;
      s_sleep_evt |=> state_reg == PM_RUN && cpu_clk_en && core_clk_en;
   endproperty
   a_sleep_wake : assert property (p_sleep_wake) else $error("sleep did not wake");

   property p_stop_clk;
      state_reg == PM_STOP |-> !core_clk_en && fast_clocks_en == 3'h0 && core_rst_n;
   endproperty
   a_stop_clk : assert property (p_stop_clk) else $error("clock running in stop");

   property p_stop_mode;
      state_reg == PM_STOP |-> regulator_mode == (ctrl_reg[CTL_LP] ? REG_LP : REG_MAIN);
   endproperty
   a_stop_mode : assert property (p_stop_mode) else $error("wrong stop regulator mode");

   property p_stop_exit;
      state_reg == PM_STOP && line_rise && !hard_rst |=> state_reg == PM_RUN;
   endproperty
   a_stop_exit : assert property (p_stop_exit) else $error("stop did not exit");

   property p_stby_exit;
      s_stby_wake |=> s_boot_hold;
   endproperty
   a_stby_exit : assert property (p_stby_exit) else $error("standby wake not a reset");

   property p_boot_reg;
      $rose(core_rst_n) |-> regulator_en && $past(regulator_en, 8);
   endproperty
   a_boot_reg : assert property (p_boot_reg) else $error("reset released unpowered");

   property p_bkp_keep;
      core_rst |=> $stable(bkp_reg);
   endproperty
   a_bkp_keep : assert property (p_bkp_keep) else $error("backup lost in reset");
endmodule // pmc_top

// File: tb/pmc_supply_model.sv
// supply comparators as the core domain sees them
`timescale 1ns/1ps
module pmc_supply_model #(
   parameter int POR_MV  = 1900,
   parameter int TH_BASE = 2200,
   parameter int TH_STEP = 100
)(
   // clock
   input  wire logic        mclk,
   // supply level in millivolts and detector setup
   input  wire logic [15:0] supply_mv,
   input  wire logic        detector_en,
   input  wire logic [2:0]  detector_threshold,
   // comparator outputs
   output logic             power_down_reset_detect,
   output logic             supply_voltage_detector
);
   logic [2:0] wander = 3'h0;
   // a switched-off comparator has no settled level; it wanders slowly enough for the
   // pin filter to pass it, so only the block's own gating keeps the detector quiet
   always @(posedge mclk) wander <= wander + 3'h1;
   assign power_down_reset_detect = (int'(supply_mv) >= POR_MV);
   assign supply_voltage_detector = detector_en ?
      (int'(supply_mv) < TH_BASE + TH_STEP * int'(detector_threshold)) : wander[2];
endmodule // pmc_supply_model

// File: tb/pmc_top_bench.sv
// self-checking bench of the power mode controller
`timescale 1ns/1ps
module pmc_top_bench
   import pmc_pkg::*;
;
   localparam logic [15:0] V_HI  = 16'h0CE4;
   localparam logic [15:0] V_LOW = 16'h0960;
   localparam logic [15:0] V_OFF = 16'h05DC;
   localparam logic [8:0]  O_RUN = {2'h3, 3'h7, 2'h3, REG_MAIN};
   localparam logic [8:0]  O_SLP = {2'h1, 3'h7, 2'h3, REG_MAIN};
   localparam logic [8:0]  O_SBY = {2'h0, 3'h0, 2'h2, REG_OFF};
   logic          mclk = 1'b0;
   logic          rst_n = 1'b0;
   logic [AW-1:0] reg_addr = '0;
   logic [DW-1:0] reg_wdata = '0, reg_rdata, rd_val;
   logic          reg_wr = 1'b0, reg_rd = 1'b0, irq, supply_ok, below, det_en;
   logic [2:0]    det_thr, fast_clocks_en;
   logic          ext_rst_n = 1'b1, wake = 1'b0, alarm = 1'b0, wdog_rst = 1'b0;
   logic [15:0]   ext_lines = '0, supply_mv = V_HI;
   logic          periph_event = 1'b0;
   logic          core_rst_n, cpu_clk_en, core_clk_en, slow_clocks_en, regulator_en;
   logic [1:0]    regulator_mode;
   int            mismatches = 0, checks_done = 0, n;

   initial forever #2 mclk = ~mclk;

   pmc_supply_model SUP (.mclk(mclk), .supply_mv(supply_mv), .detector_en(det_en),
      .detector_threshold(det_thr), .power_down_reset_detect(supply_ok),
      .supply_voltage_detector(below));

   pmc_top DUT (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
      .power_down_reset_detect(supply_ok), .supply_voltage_detector(below),
      .detector_en(det_en), .detector_threshold(det_thr),
      .external_reset_pin_n(ext_rst_n), .wake_up_pin(wake), .alarm(alarm),
      .independent_watchdog(wdog_rst), .external_interrupt_lines(ext_lines),
      .periph_event(periph_event), .core_rst_n(core_rst_n), .cpu_clk_en(cpu_clk_en),
      .core_clk_en(core_clk_en), .fast_clocks_en(fast_clocks_en),
      .slow_clocks_en(slow_clocks_en), .regulator_en(regulator_en),
      .regulator_mode(regulator_mode));

   function automatic logic [8:0] outs();
      return {cpu_clk_en, core_clk_en, fast_clocks_en, slow_clocks_en, regulator_en,
              regulator_mode};
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // sample a little after the edge so registered outputs have landed
   task automatic tick(input int k);
      repeat (k) @(posedge mclk);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr    <= 1'b0;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string w);
      @(posedge mclk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd   <= 1'b0;
      #1 rd_val = reg_rdata;
      chk(rd_val, e, w);
   endtask

   task automatic pulse_periph();
      @(posedge mclk);
      periph_event <= 1'b1;
      @(posedge mclk);
      periph_event <= 1'b0;
   endtask

   task automatic wait_core(input int least);
      for (n = 0; core_rst_n !== 1'b1 && n < 80; n++)
         tick(1);
      chk(32'(n >= least && core_rst_n === 1'b1), 32'h1, "core reset hold");
   endtask

   task automatic t_reset();
      chk(32'(outs()), 32'({2'h1, 3'h7, 2'h3, REG_MAIN}), "outputs in reset");
      wait_core(RST_HOLD_CYC);
      chk(32'(outs()), 32'(O_RUN), "run outputs");
      rchk(OFS_CTRL, 32'h0, "ctrl reset");
      rchk(OFS_MASK, 32'h0, "mask reset");
      rchk(OFS_STAT, 32'h0, "status reset");
      rchk(OFS_STATE, 32'(PM_RUN), "state reset");
      $display("test reset done");
   endtask

   task automatic t_regs();
      wr(OFS_BKP, 32'hA5C30F96);
      wr(8'h18, 32'hFFFFFFFF);
      rchk(8'h18, 32'h0, "unmapped read");
      rchk(OFS_BKP, 32'hA5C30F96, "backup rw");
      wr(OFS_CTRL, 32'hFFFFFF70);
      wr(OFS_STATE, 32'h0);
      rchk(OFS_CTRL, 32'h70, "ctrl width");
      rchk(OFS_STATE, 32'(PM_RUN), "state read only");
      chk({28'h0, det_en, det_thr}, 32'h7, "threshold out");
      wr(OFS_CTRL, 32'h0);
      $display("test regs done");
   endtask

   task automatic t_detector();
      wr(OFS_MASK, 32'h1);
      wr(OFS_CTRL, 32'h3A);
      tick(10);
      wr(OFS_STAT, 32'h7);
      tick(3);
      chk({28'h0, det_en, det_thr}, 32'hB, "detector enable out");
      chk(32'(irq), 32'h0, "no event at steady supply");
      supply_mv <= V_LOW;
      for (n = 0; irq !== 1'b1 && n < 20; n++)
         tick(1);
      chk(32'(irq), 32'h1, "fall event");
      rchk(OFS_STATE, 32'h8 | 32'(PM_RUN), "detector level");
      wr(OFS_STAT, 32'h1);
      tick(3);
      chk(32'(irq), 32'h0, "status cleared");
      supply_mv <= V_HI;
      tick(10);
      chk(32'(irq), 32'h0, "rise ignored when fall only");
      wr(OFS_CTRL, 32'h36);
      tick(10);
      wr(OFS_STAT, 32'h7);
      supply_mv <= V_LOW;
      tick(10);
      chk(32'(irq), 32'h0, "fall ignored when rise only");
      supply_mv <= V_HI;
      for (n = 0; irq !== 1'b1 && n < 20; n++)
         tick(1);
      chk(32'(irq), 32'h1, "rise event");
      wr(OFS_MASK, 32'h0);
      tick(3);
      chk(32'(irq), 32'h0, "masked event");
      rchk(OFS_STAT, 32'h1, "masked status kept");
      wr(OFS_CTRL, 32'h0);
      wr(OFS_STAT, 32'h7);
      supply_mv <= V_LOW;
      tick(12);
      rchk(OFS_STAT, 32'h0, "disabled detector quiet");
      supply_mv <= V_HI;
      tick(12);
      rchk(OFS_STAT, 32'h0, "disabled detector quiet");
      $display("test detector done");
   endtask

   task automatic t_sleep();
      wr(OFS_ENTER, 32'(ENT_SLEEP));
      tick(3);
      chk(32'(outs()), 32'(O_SLP), "sleep outputs");
      pulse_periph();
      for (n = 0; cpu_clk_en !== 1'b1 && n < 10; n++)
         tick(1);
      chk(32'(outs()), 32'(O_RUN), "sleep wake");
      $display("test sleep done");
   endtask

   task automatic t_stop(input logic lp, input logic [15:0] lines, input logic al);
      wr(OFS_CTRL, {31'h0, lp});
      wr(OFS_MASK, 32'h2);
      wr(OFS_ENTER, 32'(ENT_STOP));
      tick(3);
      chk(32'(outs()), {23'h0, 7'h03, lp ? REG_LP : REG_MAIN}, "stop outputs");
      // stop must ignore the same-clock event that ends sleep
      pulse_periph();
      tick(8);
      chk(32'(outs()), {23'h0, 7'h03, lp ? REG_LP : REG_MAIN}, "stop held");
      @(posedge mclk);
      ext_lines <= lines;
      alarm     <= al;
      for (n = 0; cpu_clk_en !== 1'b1 && n < 20; n++)
         tick(1);
      tick(1);
      chk(32'(outs()), 32'(O_RUN), "stop wake");
      chk(32'(irq), 32'h1, "stop wake irq");
      rchk(OFS_STAT, 32'h2, "stop wake status");
      rchk(OFS_CTRL, {31'h0, lp}, "ctrl retained");
      ext_lines <= '0;
      alarm     <= 1'b0;
      wr(OFS_STAT, 32'h2);
   endtask

   task automatic t_standby(input int s);
      wr(OFS_BKP, 32'hC0DE0000 + 32'(s));
      wr(OFS_CTRL, 32'h1);
      wr(OFS_ENTER, 32'(ENT_STBY));
      tick(3);
      chk(32'(outs()), 32'(O_SBY), "standby outputs");
      chk(32'(core_rst_n), 32'h0, "core off");
      @(posedge mclk);
      case (s)
         0: wake <= 1'b1;
         1: alarm <= 1'b1;
         2: ext_rst_n <= 1'b0;
         default: wdog_rst <= 1'b1;
      endcase
      // sources stay driven until the regulator is back, so the hold is timed from there
      for (n = 0; regulator_en !== 1'b1 && n < 30; n++)
         tick(1);
      chk({30'h0, regulator_en, core_rst_n}, 32'h2, "regulator before reset");
      wake      <= 1'b0;
      alarm     <= 1'b0;
      ext_rst_n <= 1'b1;
      wdog_rst  <= 1'b0;
      wait_core(RST_HOLD_CYC);
      chk(32'(outs()), 32'(O_RUN), "standby exit");
      rchk(OFS_CTRL, 32'h0, "contents lost");
      rchk(OFS_BKP, 32'hC0DE0000 + 32'(s), "backup kept");
      rchk(OFS_STAT, (s < 2) ? 32'h4 : 32'h0, "standby wake status");
      wr(OFS_STAT, 32'h4);
      $display("test standby %0d done", s);
   endtask

   task automatic t_supply();
      supply_mv <= V_OFF;
      tick(10);
      chk({29'h0, core_rst_n, regulator_mode}, 32'(REG_MAIN), "supply low reset");
      tick(40);
      chk(32'(core_rst_n), 32'h0, "reset held");
      wr(OFS_BKP, 32'h00000000);
      rchk(OFS_BKP, 32'h0, "no access in reset");
      supply_mv <= V_HI;
      wait_core(RST_HOLD_CYC);
      rchk(OFS_BKP, 32'hC0DE0003, "backup after power reset");
      $display("test supply done");
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial
   begin
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      t_reset();
      t_regs();
      t_detector();
      t_sleep();
      for (int i = 0; i < 16; i++)
         t_stop(i[0], 16'h0001 << i, 1'b0);
      t_stop(1'b1, 16'h0000, 1'b1);
      $display("test stop done");
      for (int s = 0; s < 4; s++)
         t_standby(s);
      t_supply();
      print_verdict();
   end

   // whole run is near 1000 cycles, so this leaves ample slack
   initial
   begin
      repeat (20000) @(posedge mclk);
      mismatches++;
      $display("BAD %0t run did not finish", $time);
      print_verdict();
   end
endmodule // pmc_top_bench
